// file: hdl/comm_params_pkg.sv
package comm_params_pkg;
    localparam int          ADDR_W            = 4;
    localparam int          DATA_W            = 16;
    localparam logic [3:0]  OFS_DOUT          = 4'h0;
    localparam logic [3:0]  OFS_AOUT          = 4'h1;
    localparam logic [3:0]  OFS_SER_STATUS    = 4'h2;
    localparam logic [3:0]  OFS_RX_TELEGRAM   = 4'h3;
    localparam logic [3:0]  OFS_TX_TELEGRAM   = 4'h4;
    localparam logic [3:0]  OFS_BAD_CHECK     = 4'h5;
    localparam logic [3:0]  OFS_RX_ERROR      = 4'h6;
    localparam logic [3:0]  OFS_MODULE_ID     = 4'h7;
    localparam logic [3:0]  OFS_MODULE_STATE  = 4'h8;
    localparam logic [3:0]  OFS_CFG_STATUS    = 4'h9;
    localparam logic [3:0]  OFS_CFG_CONTROL   = 4'ha;
    localparam logic [3:0]  OFS_CFG_SOURCES   = 4'hb;
    localparam int          DOUT_W            = 3;
    localparam int          AOUT_W            = 10;
    localparam logic [2:0]  DOUT_RESET        = 3'h0;
    localparam logic [9:0]  AOUT_RESET        = 10'h000;
    localparam int          CFG_W             = 7;
    localparam int          CFG_INIT_BIT      = 0;
    localparam int          CFG_DOWNLOAD_BIT  = 1;
    localparam int          CFG_GUIDED_BIT    = 2;
    localparam int          CFG_INCOMPAT_BIT  = 3;
    localparam int          CFG_RESET_BIT     = 4;
    localparam int          CFG_COPY_BIT      = 5;
    localparam int          CFG_TEST_BIT      = 6;
    localparam int          ABORT_BIT         = 0;
    localparam int          CURRENT_W         = 16;
    localparam int          LIMIT_FACTOR      = 5;
    localparam int          MODULE_ID_MAX     = 25;
    localparam int          MODULE_ID_FIRST   = 16;
    typedef enum logic [1:0] {
        SER_OFF     = 2'b00,
        SER_ON      = 2'b01,
        SER_TIMEOUT = 2'b10
    } ser_status_e;
    typedef enum logic [3:0] {
        MOD_SETUP       = 4'b0000,
        MOD_INIT        = 4'b0001,
        MOD_WAIT_COMM   = 4'b0010,
        MOD_IDLE        = 4'b0011,
        MOD_DATA_ACTIVE = 4'b0100,
        MOD_EXCEPTION   = 4'b0111,
        MOD_ACCESS_ERR  = 4'b1000
    } mod_state_e;
    // Digital input function selects
    localparam logic [2:0]  FN_NONE     = 3'h0;
    localparam logic [2:0]  FN_ENABLE   = 3'h1;
    localparam logic [2:0]  FN_START    = 3'h2;
    localparam logic [2:0]  FN_STOP     = 3'h3;
    localparam logic [2:0]  FN_REMOTE   = 3'h4;
    localparam logic [2:0]  FN_USERLOAD = 3'h5;
    localparam int          NUM_INS     = 6;
endpackage

// file: hdl/comm_status_output_params.sv
// Added by the designer: the register offsets and the address-and-strobe port.
module comm_status_output_params
    import comm_params_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic [ADDR_W-1:0]     regAddr,
    input  wire logic [DATA_W-1:0]     regWdata,
    input  wire logic                  regWrite,
    input  wire logic                  regRead,
    output logic      [DATA_W-1:0]     regRdata,
    input  wire logic                  serialPresent,
    input  wire logic                  serialLinkAlarm,
    input  wire logic                  serialLinkFault,
    input  wire logic                  telegramRx,
    input  wire logic                  telegramTx,
    input  wire logic                  badCheckRx,
    input  wire logic                  byteRxError,
    input  wire logic [4:0]            moduleIdIn,
    input  wire logic [3:0]            moduleStateIn,
    input  wire logic                  sysInitializing,
    input  wire logic                  fwDownloading,
    input  wire logic                  guidedStartup,
    input  wire logic                  resetNeeded,
    input  wire logic                  panelCopying,
    input  wire logic                  testMode,
    input  wire logic [3*NUM_INS-1:0]  inputFn,
    input  wire logic [CURRENT_W-1:0]  currentLimit,
    input  wire logic [CURRENT_W-1:0]  ratedCurrent,
    input  wire logic                  configChanged,
    input  wire logic                  startRequest,
    output logic                       digital_output_one,
    output logic                       digital_output_two,
    output logic                       digital_output_three,
    output logic      [AOUT_W-1:0]     analog_output_level,
    output logic                       motorStartAllowed,
    output logic                       guidedAbort,
    output logic                       showCauseMessage
);
    // Pin-level inputs pass a two-stage synchroniser
    localparam int SYNC_W = 11;
    logic [SYNC_W-1:0] syncA_q;
    logic [SYNC_W-1:0] syncB_q;
    logic              serPresentS;
    logic              serAlarmS;
    logic              serFaultS;
    logic              rxS;
    logic              txS;
    logic              badS;
    logic              errS;
    logic              initS;
    logic              dlS;
    logic              guidedS;
    logic              resetS;
    logic              copyS;
    logic              testS;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            syncA_q <= '0;
            syncB_q <= '0;
        end else begin
            syncA_q <= {serialPresent, serialLinkAlarm, serialLinkFault, telegramRx, telegramTx,
                        badCheckRx, byteRxError, sysInitializing, fwDownloading, resetNeeded,
                        panelCopying};
            syncB_q <= syncA_q;
        end
    end
    assign {serPresentS, serAlarmS, serFaultS, rxS, txS, badS, errS, initS, dlS, resetS, copyS} = syncB_q;

    logic [1:0] syncC_q;
    logic [1:0] syncD_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            syncC_q <= '0;
            syncD_q <= '0;
        end else begin
            syncC_q <= {guidedStartup, testMode};
            syncD_q <= syncC_q;
        end
    end
    assign {guidedS, testS} = syncD_q;

    // Event strobes may last many cycles; count each on its rising edge
    logic [3:0] evtPrev_q;
    logic [3:0] evtPulse;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            evtPrev_q <= '0;
        end else begin
            evtPrev_q <= {rxS, txS, badS, errS};
        end
    end
    assign evtPulse = {rxS, txS, badS, errS} & ~evtPrev_q;

    // Counters: 0 rx, 1 tx, 2 bad check, 3 rx error
    logic [DATA_W-1:0] serCount_q [4];
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_cnt
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    serCount_q[gi] <= '0;
                end else if (evtPulse[3-gi]) begin
                    serCount_q[gi] <= serCount_q[gi] + 16'h0001;
                end
            end
        end
    endgenerate

    // Serial interface status
    ser_status_e serStatus_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            serStatus_q <= SER_OFF;
        end else if (!serPresentS) begin
            serStatus_q <= SER_OFF;
        end else if (serAlarmS || serFaultS) begin
            serStatus_q <= SER_TIMEOUT;
        end else begin
            serStatus_q <= SER_ON;
        end
    end

    // Module identification and state; out-of-range codes are held at safe values
    logic [4:0] moduleId_q;
    mod_state_e moduleState_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            moduleId_q <= 5'h00;
        end else if (moduleIdIn > 5'(MODULE_ID_MAX)) begin
            moduleId_q <= 5'h00;
        end else begin
            moduleId_q <= moduleIdIn;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            moduleState_q <= MOD_SETUP;
        end else begin
            case (moduleStateIn)
                4'h0:    moduleState_q <= MOD_SETUP;
                4'h1:    moduleState_q <= MOD_INIT;
                4'h2:    moduleState_q <= MOD_WAIT_COMM;
                4'h3:    moduleState_q <= MOD_IDLE;
                4'h4:    moduleState_q <= MOD_DATA_ACTIVE;
                4'h7:    moduleState_q <= MOD_EXCEPTION;
                4'h8:    moduleState_q <= MOD_ACCESS_ERR;
                default: moduleState_q <= MOD_EXCEPTION;
            endcase
        end
    end

    // Parameter compatibility check
    function automatic logic [2:0] countFn(input logic [3*NUM_INS-1:0] sel, input logic [2:0] fn);
        logic [2:0] n;
        n = 3'h0;
        for (int i = 0; i < NUM_INS; i++) begin
            if (sel[3*i +: 3] == fn) begin
                n = n + 3'h1;
            end
        end
        return n;
    endfunction

    logic [2:0]           nEnable;
    logic [2:0]           nStart;
    logic [2:0]           nStop;
    logic [2:0]           nLocRem;
    logic [2:0]           nLoad;
    logic [CURRENT_W+2:0] limitMax;
    logic                 incompat;
    assign nEnable  = countFn(inputFn, FN_ENABLE);
    assign nStart   = countFn(inputFn, FN_START);
    assign nStop    = countFn(inputFn, FN_STOP);
    assign nLocRem  = countFn(inputFn, FN_REMOTE);
    assign nLoad    = countFn(inputFn, FN_USERLOAD);
    assign limitMax = (CURRENT_W+3)'(ratedCurrent) * (CURRENT_W+3)'(LIMIT_FACTOR);
    assign incompat = (nEnable > 3'h1) || (nStart > 3'h1) || (nStop > 3'h1)
                   || (nLocRem > 3'h1) || (nLoad > 3'h1)
                   || ((nStart != 3'h0) != (nStop != 3'h0))
                   || ((CURRENT_W+3)'(currentLimit) > limitMax);

    // Settings come from other logic on clk; a registered flag eases timing
    logic incompat_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            incompat_q <= 1'b0;
        end else begin
            incompat_q <= incompat;
        end
    end

    logic [CFG_W-1:0] cfgStatus;
    assign cfgStatus = {testS, copyS, resetS, incompat_q, guidedS, dlS, initS};

    // Software-written registers
    logic [DOUT_W-1:0] dout_q;
    logic [AOUT_W-1:0] aout_q;
    logic              abortReq_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dout_q <= DOUT_RESET;
        end else if (regWrite && regAddr == OFS_DOUT) begin
            dout_q <= regWdata[DOUT_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aout_q <= AOUT_RESET;
        end else if (regWrite && regAddr == OFS_AOUT) begin
            aout_q <= regWdata[AOUT_W-1:0];
        end
    end

    // Abort bit stays set until guided start-up has ended
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            abortReq_q <= 1'b0;
        end else if (regWrite && regAddr == OFS_CFG_CONTROL) begin
            abortReq_q <= regWdata[ABORT_BIT];
        end else if (!guidedS) begin
            abortReq_q <= 1'b0;
        end
    end

    // Outputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            digital_output_one   <= 1'b0;
            digital_output_two   <= 1'b0;
            digital_output_three <= 1'b0;
            analog_output_level  <= AOUT_RESET;
        end else begin
            {digital_output_three, digital_output_two, digital_output_one} <= dout_q;
            analog_output_level <= aout_q;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            motorStartAllowed <= 1'b0;
            guidedAbort       <= 1'b0;
        end else begin
            motorStartAllowed <= (cfgStatus[CFG_TEST_BIT-1:0] == '0);
            guidedAbort       <= abortReq_q && guidedS;
        end
    end

    // Cause message: first cycle after reset, on a start attempt or a change
    logic powerUp_q;
    logic startPrev_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            powerUp_q        <= 1'b1;
            startPrev_q      <= 1'b0;
            showCauseMessage <= 1'b0;
        end else begin
            powerUp_q        <= 1'b0;
            startPrev_q      <= startRequest;
            // Flag register is still clear at the first edge, so power-up uses the live check
            showCauseMessage <= (powerUp_q && incompat)
                                || (incompat_q && ((startRequest && !startPrev_q) || configChanged));
        end
    end

    // Register read port, answer one cycle after the strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdata <= '0;
        end else if (regRead) begin
            case (regAddr)
                OFS_DOUT:         regRdata <= DATA_W'(dout_q);
                OFS_AOUT:         regRdata <= DATA_W'(aout_q);
                OFS_SER_STATUS:   regRdata <= DATA_W'(serStatus_q);
                OFS_RX_TELEGRAM:  regRdata <= serCount_q[0];
                OFS_TX_TELEGRAM:  regRdata <= serCount_q[1];
                OFS_BAD_CHECK:    regRdata <= serCount_q[2];
                OFS_RX_ERROR:     regRdata <= serCount_q[3];
                OFS_MODULE_ID:    regRdata <= DATA_W'(moduleId_q);
                OFS_MODULE_STATE: regRdata <= DATA_W'(moduleState_q);
                OFS_CFG_STATUS:   regRdata <= DATA_W'(cfgStatus);
                OFS_CFG_CONTROL:  regRdata <= DATA_W'(abortReq_q);
                default:          regRdata <= '0;
            endcase
        end else begin
            regRdata <= '0;
        end
    end

    // Checks
    AST_DOUT_FOLLOWS: assert property (@(posedge clk) disable iff (!rst_n)
        regWrite && regAddr == OFS_DOUT |-> ##2 digital_output_one == $past(regWdata[0], 2))
        else $error("digital output one does not follow write");
    AST_AOUT_FOLLOWS: assert property (@(posedge clk) disable iff (!rst_n)
        regWrite && regAddr == OFS_AOUT |-> ##2 analog_output_level == $past(regWdata[9:0], 2))
        else $error("analog level does not follow write");
    AST_SER_OFF: assert property (@(posedge clk) disable iff (!rst_n)
        !serPresentS |=> serStatus_q == SER_OFF)
        else $error("serial status not off while absent");
    AST_SER_TIMEOUT: assert property (@(posedge clk) disable iff (!rst_n)
        serPresentS && (serAlarmS || serFaultS) |=> serStatus_q == SER_TIMEOUT)
        else $error("serial status not timeout on alarm");
    AST_RX_COUNT: assert property (@(posedge clk) disable iff (!rst_n)
        evtPulse[3] |=> serCount_q[0] == $past(serCount_q[0]) + 16'h0001)
        else $error("rx counter did not step");
    AST_TX_COUNT: assert property (@(posedge clk) disable iff (!rst_n)
        !evtPulse[2] |=> $stable(serCount_q[1]))
        else $error("tx counter moved without event");
    AST_WRAP: assert property (@(posedge clk) disable iff (!rst_n)
        evtPulse[1] && serCount_q[2] == 16'hffff |=> serCount_q[2] == 16'h0000)
        else $error("bad check counter did not wrap");
    AST_NO_START: assert property (@(posedge clk) disable iff (!rst_n)
        incompat_q |=> !motorStartAllowed)
        else $error("start allowed while incompatible");
    AST_START_STOP: assert property (@(posedge clk) disable iff (!rst_n)
        (nStart != 3'h0) && (nStop == 3'h0) |=> incompat_q)
        else $error("start without stop not flagged");
    AST_ABORT: assert property (@(posedge clk) disable iff (!rst_n)
        regWrite && regAddr == OFS_CFG_CONTROL && regWdata[0] && guidedS ##1 guidedS |=> guidedAbort)
        else $error("guided abort not raised");
    COV_RX: cover property (@(posedge clk) disable iff (!rst_n) evtPulse[3]);
    COV_TIMEOUT: cover property (@(posedge clk) disable iff (!rst_n) serStatus_q == SER_TIMEOUT);
    COV_INCOMPAT: cover property (@(posedge clk) disable iff (!rst_n) showCauseMessage);
    COV_ABORT: cover property (@(posedge clk) disable iff (!rst_n) guidedAbort);
    COV_POWER_UP: cover property (@(posedge clk) disable iff (!rst_n) $fell(powerUp_q) && showCauseMessage);
    // Reserved upper bits must read as zero whatever was written
    AST_DOUT_RESERVED: assert property (@(posedge clk) disable iff (!rst_n)
        regRead && regAddr == OFS_DOUT |=> regRdata[DATA_W-1:DOUT_W] == '0)
        else $error("reserved output bits read non-zero");
    AST_CFG_RESERVED: assert property (@(posedge clk) disable iff (!rst_n)
        regRead && regAddr == OFS_CFG_STATUS |=> regRdata[DATA_W-1:CFG_W] == '0)
        else $error("reserved status bits read non-zero");
    AST_BAD_COUNT: assert property (@(posedge clk) disable iff (!rst_n)
        evtPulse[1] |=> serCount_q[2] == $past(serCount_q[2]) + 16'h0001)
        else $error("bad check counter did not step");
    AST_ERR_COUNT: assert property (@(posedge clk) disable iff (!rst_n)
        evtPulse[0] |=> serCount_q[3] == $past(serCount_q[3]) + 16'h0001)
        else $error("rx error counter did not step");
    AST_ID_RANGE: assert property (@(posedge clk) disable iff (!rst_n)
        moduleIdIn > 5'(MODULE_ID_MAX) |=> moduleId_q == 5'h00)
        else $error("out-of-range module id not cleared");
    // Unused state codes report the exception code
    AST_STATE_UNUSED: assert property (@(posedge clk) disable iff (!rst_n)
        (moduleStateIn == 4'h5 || moduleStateIn == 4'h6) |=> moduleState_q == MOD_EXCEPTION)
        else $error("unused module state not mapped");
    AST_CAUSE: assert property (@(posedge clk) disable iff (!rst_n)
        incompat_q && configChanged |=> showCauseMessage)
        else $error("cause message missing on change");
endmodule

// file: tb/serial_master_model.sv
module serial_master_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [3:0] fire,
    input  wire logic       slow,
    output logic            telegramRx,
    output logic            telegramTx,
    output logic            badCheckRx,
    output logic            byteRxError,
    output logic            busy
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] mask_q;
    logic [3:0] cnt_q;
    logic [3:0] len_q;
    logic       high;

    // Each event stays high, then low, for len_q cycles so the synchroniser sees both levels
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_q <= 4'h0;
            cnt_q  <= 4'h0;
            len_q  <= 4'h2;
        end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end else if (fire != 4'h0) begin
            mask_q <= fire;
            len_q  <= slow ? 4'h5 : 4'h2;
            cnt_q  <= slow ? 4'ha : 4'h4;
        end
    end

    assign high        = cnt_q > len_q;
    assign telegramRx  = mask_q[0] & high;
    assign telegramTx  = mask_q[1] & high;
    assign badCheckRx  = mask_q[2] & high;
    assign byteRxError = mask_q[3] & high;
    assign busy        = cnt_q != 4'h0;
endmodule

// file: tb/test_comm_status_output_params.sv
module test_comm_status_output_params import comm_params_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int LIMIT = 5000;
    logic                 clk;
    logic                 rst_n;
    logic [ADDR_W-1:0]    regAddr;
    logic [DATA_W-1:0]    regWdata;
    logic [DATA_W-1:0]    regRdata;
    logic                 regWrite;
    logic                 regRead;
    logic                 serialPresent;
    logic                 serialLinkAlarm;
    logic                 serialLinkFault;
    logic                 telegramRx;
    logic                 telegramTx;
    logic                 badCheckRx;
    logic                 byteRxError;
    logic [4:0]           moduleIdIn;
    logic [3:0]           moduleStateIn;
    logic [6:0]           cfgIn;
    logic [3*NUM_INS-1:0] inputFn;
    logic [CURRENT_W-1:0] currentLimit;
    logic [CURRENT_W-1:0] ratedCurrent;
    logic                 configChanged;
    logic                 startRequest;
    logic                 doOne;
    logic                 doTwo;
    logic                 doThree;
    logic [AOUT_W-1:0]    aoutLevel;
    logic                 motorStartAllowed;
    logic                 guidedAbort;
    logic                 showCauseMessage;
    logic [3:0]           fire;
    logic                 slow;
    logic                 busy;
    logic                 rdPend_q;
    logic [15:0]          expQ[$];
    logic [15:0]          cnt[4];
    logic [15:0]          r;
    logic [3:0]           m;
    int                   seed = 32'h3697e6bf;
    int                   errors = 0;
    int                   checks = 0;
    int                   cycles = 0;

    comm_status_output_params dut (
        .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
        .regRead(regRead), .regRdata(regRdata), .serialPresent(serialPresent),
        .serialLinkAlarm(serialLinkAlarm), .serialLinkFault(serialLinkFault), .telegramRx(telegramRx),
        .telegramTx(telegramTx), .badCheckRx(badCheckRx), .byteRxError(byteRxError),
        .moduleIdIn(moduleIdIn), .moduleStateIn(moduleStateIn), .sysInitializing(cfgIn[0]),
        .fwDownloading(cfgIn[1]), .guidedStartup(cfgIn[2]), .resetNeeded(cfgIn[4]),
        .panelCopying(cfgIn[5]), .testMode(cfgIn[6]), .inputFn(inputFn),
        .currentLimit(currentLimit), .ratedCurrent(ratedCurrent), .configChanged(configChanged),
        .startRequest(startRequest), .digital_output_one(doOne), .digital_output_two(doTwo),
        .digital_output_three(doThree), .analog_output_level(aoutLevel),
        .motorStartAllowed(motorStartAllowed), .guidedAbort(guidedAbort), .showCauseMessage(showCauseMessage)
    );

    serial_master_model partner (
        .clk(clk), .rst_n(rst_n), .fire(fire), .slow(slow), .telegramRx(telegramRx),
        .telegramTx(telegramTx), .badCheckRx(badCheckRx), .byteRxError(byteRxError), .busy(busy)
    );

    initial clk = 1'b0;
    always #5 clk = ~clk;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("Checks %0d, errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // An idle cycle after each strobe keeps one assignment per signal per time step
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        regAddr  <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        regAddr <= a;
        regRead <= 1'b1;
        expQ.push_back(exp);
        @(posedge clk);
        regRead <= 1'b0;
        @(posedge clk);
    endtask

    task automatic settle();
        repeat (5) @(posedge clk);
    endtask

    task automatic pulse(input logic [3:0] mask);
        fire <= mask;
        @(posedge clk);
        fire <= 4'h0;
        @(posedge clk);
        while (busy) @(posedge clk);
    endtask

    function automatic logic [17:0] inFn(input logic [2:0] a, input logic [2:0] b, input logic [2:0] c);
        return {9'h0, c, b, a};
    endfunction

    task automatic cfgCase(input logic [17:0] sel, input logic [15:0] lim, input logic bad);
        inputFn      <= sel;
        currentLimit <= lim;
        settle();
        rd(OFS_CFG_STATUS, bad ? 16'h8 : 16'h0);
        check(16'(motorStartAllowed), 16'(!bad));
    endtask

    task automatic cause(input logic viaStart, input logic exp);
        logic seen;
        seen = 1'b0;
        startRequest  <= viaStart;
        configChanged <= !viaStart;
        @(posedge clk);
        startRequest  <= 1'b0;
        configChanged <= 1'b0;
        repeat (4) begin
            @(posedge clk);
            seen |= showCauseMessage;
        end
        check(16'(seen), 16'(exp));
    endtask

    // Read data is compared only in the cycle after the strobe
    always @(posedge clk) begin
        rdPend_q <= regRead;
        if (rdPend_q) begin
            if (expQ.size() == 0) begin
                errors++;
            end else begin
                check(regRdata, expQ.pop_front());
            end
        end
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            errors++;
            conclude();
        end
    end

    initial begin
        rst_n <= 1'b0; regAddr <= 4'h0; regWdata <= 16'h0; regWrite <= 1'b0; regRead <= 1'b0;
        serialPresent <= 1'b0; serialLinkAlarm <= 1'b0; serialLinkFault <= 1'b0;
        moduleIdIn <= 5'h0; moduleStateIn <= 4'h0; cfgIn <= 7'h0; inputFn <= 18'h0;
        currentLimit <= 16'h0; ratedCurrent <= 16'h0; configChanged <= 1'b0; startRequest <= 1'b0;
        fire <= 4'h0; slow <= 1'b0;
        for (int k = 0; k < 4; k++) cnt[k] = 16'h0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int a = 0; a < 16; a++) rd(4'(a), 16'h0);
        check(16'(motorStartAllowed), 16'h1);
        for (int i = 0; i < 8; i++) begin
            r = (i == 0) ? 16'hffff : 16'($random(seed));
            wr(OFS_DOUT, r);
            rd(OFS_DOUT, r & 16'h0007);
            check(16'({doThree, doTwo, doOne}), r & 16'h0007);
            wr(OFS_AOUT, r);
            rd(OFS_AOUT, r & 16'h03ff);
            check(16'(aoutLevel), r & 16'h03ff);
        end
        wr(4'hb, 16'hffff);
        rd(OFS_DOUT, r & 16'h0007);
        for (int i = 0; i < 12; i++) begin
            m = 4'($random(seed));
            slow <= i[0];
            pulse(m);
            for (int k = 0; k < 4; k++) cnt[k] += 16'(m[k]);
        end
        settle();
        wr(OFS_RX_TELEGRAM, 16'hffff);
        for (int k = 0; k < 4; k++) rd(OFS_RX_TELEGRAM + 4'(k), cnt[k]);
        for (int v = 0; v < 8; v++) begin
            serialPresent   <= v[0];
            serialLinkAlarm <= v[1] & v[0];
            serialLinkFault <= v[2] & v[0];
            settle();
            rd(OFS_SER_STATUS, !v[0] ? 16'h0 : (v[2:1] != 0 ? 16'h2 : 16'h1));
        end
        for (int v = 0; v < 32; v++) begin
            moduleIdIn    <= 5'(v);
            moduleStateIn <= 4'(v);
            settle();
            rd(OFS_MODULE_ID, v > MODULE_ID_MAX ? 16'h0 : 16'(v));
            rd(OFS_MODULE_STATE, (v % 16 inside {5, 6} || v % 16 > 8) ? 16'h7 : 16'(v % 16));
        end
        for (int i = 0; i < CFG_W; i++) begin
            if (i != CFG_INCOMPAT_BIT) begin
                cfgIn <= 7'(1 << i);
                settle();
                rd(OFS_CFG_STATUS, 16'(1 << i));
                check(16'(motorStartAllowed), 16'(i == CFG_TEST_BIT));
            end
        end
        cfgIn <= 7'h4;
        settle();
        wr(OFS_CFG_CONTROL, 16'hfffe);
        rd(OFS_CFG_CONTROL, 16'h0);
        check(16'(guidedAbort), 16'h0);
        wr(OFS_CFG_CONTROL, 16'hffff);
        rd(OFS_CFG_CONTROL, 16'h1);
        check(16'(guidedAbort), 16'h1);
        cfgIn <= 7'h0;
        settle();
        rd(OFS_CFG_CONTROL, 16'h0);
        check(16'(guidedAbort), 16'h0);
        cfgCase(inFn(FN_START, FN_STOP, FN_NONE), 16'h0, 1'b0);
        cfgCase(inFn(FN_START, FN_NONE, FN_NONE), 16'h0, 1'b1);
        cfgCase(inFn(FN_NONE, FN_STOP, FN_NONE), 16'h0, 1'b1);
        cfgCase(inFn(FN_START, FN_STOP, FN_START), 16'h0, 1'b1);
        cfgCase(inFn(FN_START, FN_STOP, FN_STOP), 16'h0, 1'b1);
        cfgCase(inFn(FN_ENABLE, FN_ENABLE, FN_NONE), 16'h0, 1'b1);
        cfgCase(inFn(FN_REMOTE, FN_REMOTE, FN_NONE), 16'h0, 1'b1);
        cfgCase(inFn(FN_USERLOAD, FN_USERLOAD, FN_NONE), 16'h0, 1'b1);
        cfgCase(inFn(FN_ENABLE, FN_REMOTE, FN_USERLOAD), 16'h0, 1'b0);
        r = 16'($random(seed)) & 16'h0fff;
        ratedCurrent <= r;
        cfgCase(18'h0, 16'(r * 5), 1'b0);
        cfgCase(18'h0, 16'(r * 5 + 1), 1'b1);
        cause(1'b1, 1'b1);
        cause(1'b0, 1'b1);
        // Mid-run reset with the limit still incompatible: power-up message expected
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        r = 16'h0;
        repeat (3) begin
            @(posedge clk);
            r |= 16'(showCauseMessage);
        end
        check(r, 16'h1);
        cfgCase(18'h0, 16'h0, 1'b0);
        cause(1'b1, 1'b0);
        repeat (3) @(posedge clk);
        if (expQ.size() != 0) errors++;
        conclude();
    end
endmodule
